// ==== dv/ibt_eeprom_model.sv ====
// Behavioural serial EEPROM slave on the two bus lines
`timescale 1ns/1ps
`default_nettype none
module ibt_eeprom_model (
  // Bench control
  input  wire logic        rst_i,
  input  wire logic        slave_tx_i,
  input  wire logic        nack_i,
  input  wire logic        stretch_i,
  input  wire logic [7:0]  send_i,
  // Bus lines, pull-up outside
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_oe_o,
  output logic             sda_oe_o,
  // Observation
  output logic             ack_seen_o,
  output logic [7:0]       nbytes_o,
  output logic [23:0]      hist_o
);
  logic [3:0] cnt;
  logic [3:0] idx;
  logic [7:0] sh;
  logic       hold = 1'b0;

  // Address and data bytes are simply logged in arrival order
  always @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      cnt = 4'h0;
      sh = 8'h00;
      nbytes_o = 8'h00;
      hist_o = 24'h0;
      ack_seen_o = 1'b0;
    end else begin
      if (cnt == 4'h9) cnt = 4'h0;
      if (cnt < 4'h8) sh = {sh[6:0], sda_i};
      if (cnt == 4'h7) begin
        nbytes_o = nbytes_o + 8'h01;
        hist_o = {hist_o[15:0], sh};
      end
      if (cnt == 4'h8) ack_seen_o = sda_i;
      cnt = cnt + 4'h1;
    end
  end

  // Bit index moves on falls only, so SDA never changes with SCL high
  always @(negedge scl_i or posedge rst_i) begin
    if (rst_i) idx = 4'h0;
    else idx = (cnt == 4'h9) ? 4'h0 : cnt;
  end

  assign sda_oe_o = slave_tx_i ?
    (idx < 4'h8 && !send_i[3'h7 - idx[2:0]]) : (idx == 4'h8 && !nack_i);

  // Slow slave: holds SCL low well past the master's low phase
  always @(negedge scl_i) begin
    if (stretch_i) begin
      hold = 1'b1;
      #600;
      hold = 1'b0;
    end
  end
  assign scl_oe_o = hold;
endmodule
`default_nettype wire

// ==== dv/test_i2c_master_byte_transfer_flags.sv ====
// Self-checking bench for the I2C master byte path
`timescale 1ns/1ps
`default_nettype none
module test_i2c_master_byte_transfer_flags;
  import ibt_pkg::*;
  logic [7:0]  aw_a, ar_a, s_send, s_nb, nb;
  logic [31:0] w_d, r_d, rdat;
  logic [1:0]  b_r, r_r;
  logic        clk, rst, aw_v, aw_r, w_v, w_r, b_v, b_y, ar_v, ar_r;
  logic        r_v, r_y, scl_m, sda_m, scl_s, sda_s, scl, sda, irq;
  logic        s_tx, s_nack, s_str, ack_seen, scl_d, sda_d;
  logic [3:0]  w_s;
  logic [23:0] s_hist;
  int          error_cnt, n_checks;

  assign scl = !(scl_m | scl_s);
  assign sda = !(sda_m | sda_s);

  ibt_master_top u_dut (
    .SYS_CLK_I(clk), .RST_I(rst),
    .S_AXI_AWADDR_I(aw_a), .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_r),
    .S_AXI_WDATA_I(w_d), .S_AXI_WSTRB_I(w_s), .S_AXI_WVALID_I(w_v),
    .S_AXI_WREADY_O(w_r), .S_AXI_BRESP_O(b_r), .S_AXI_BVALID_O(b_v),
    .S_AXI_BREADY_I(b_y), .S_AXI_ARADDR_I(ar_a), .S_AXI_ARVALID_I(ar_v),
    .S_AXI_ARREADY_O(ar_r), .S_AXI_RDATA_O(r_d), .S_AXI_RRESP_O(r_r),
    .S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(r_y),
    .SCL_I(scl), .SCL_O(scl_d), .SCL_OE_O(scl_m),
    .SDA_I(sda), .SDA_O(sda_d), .SDA_OE_O(sda_m), .IRQ_O(irq)
  );

  ibt_eeprom_model u_eep (
    .rst_i(rst), .slave_tx_i(s_tx), .nack_i(s_nack), .stretch_i(s_str),
    .send_i(s_send), .scl_i(scl), .sda_i(sda), .scl_oe_o(scl_s),
    .sda_oe_o(sda_s), .ack_seen_o(ack_seen), .nbytes_o(s_nb),
    .hist_o(s_hist)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic hang(input string m);
    error_cnt++;
    $display("MISMATCH t=%0t timeout %s", $time, m);
    tally_and_finish();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int i;
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_y <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      if (b_v === 1'b1) break;
    end
    if (b_v !== 1'b1) hang("write");
    b_y <= 1'b0;
    chk(b_r, er, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int i;
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_y <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (ar_r) ar_v <= 1'b0;
      if (r_v === 1'b1) break;
    end
    if (r_v !== 1'b1) hang("read");
    rdat = r_d;
    r_y <= 1'b0;
    chk(r_r, er, "read response");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] msk,
                     input logic [31:0] e, input string m);
    rd(a, RESP_OKAY);
    chk(rdat & msk, e, m);
  endtask

  // Status polling bounded so a stuck engine ends the run
  task automatic wait_st(input int b, input logic v, input string m);
    int i;
    for (i = 0; i < 400; i++) begin
      rd(ADDR_STATUS, RESP_OKAY);
      if (rdat[b] === v) return;
    end
    hang(m);
  endtask

  task automatic t_reset();
    rdc(ADDR_CTRL, 32'h7, 32'h0, "ctrl reset");
    rdc(ADDR_STATUS, 32'h3f, 32'h1, "status reset");
    rdc(ADDR_IRQ_EN, 32'hf, 32'h0, "irq enable reset");
    // Lane 0 strobe low: write answered but ignored
    w_s <= 4'he;
    wr(ADDR_IRQ_EN, 32'hf, RESP_OKAY);
    w_s <= 4'hf;
    rdc(ADDR_IRQ_EN, 32'hf, 32'h0, "masked lane ignored");
    chk({scl_d, sda_d}, 32'h0, "open drain level");
    rd(8'h14, RESP_SLVERR);
    wr(8'h14, 32'h0, RESP_SLVERR);
    chk(irq, 1'b0, "irq idle");
    $display("test reset done");
  endtask

  task automatic t_tx();
    logic [23:0] msg;
    int          i;
    msg = 24'ha00123;
    wr(ADDR_IRQ_EN, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "tx empty irq");
    wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq masked");
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      wr(ADDR_TX_HOLD, {24'h0, msg[23-8*i -: 8]}, RESP_OKAY);
      if (i > 0) rdc(ADDR_STATUS, 32'h3, 32'h0, "byte held");
      wait_st(ST_TX_EMPTY, 1'b1, "tx empty");
    end
    wait_st(ST_TX_END, 1'b1, "tx end");
    wait_st(ST_BUSY, 1'b0, "idle");
    chk(s_hist, msg, "bytes on wire");
    rdc(ADDR_STATUS, 32'h18, 32'h0, "acked");
    wr(ADDR_IRQ_EN, 32'h2, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "tx end irq");
    wr(ADDR_STATUS, 32'h2, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "tx end cleared");
    $display("test transmit done");
  endtask

  task automatic t_nack();
    @(posedge clk);
    s_nack <= 1'b1;
    wr(ADDR_IRQ_EN, 32'h8, RESP_OKAY);
    wr(ADDR_TX_HOLD, 32'h5c, RESP_OKAY);
    rdc(ADDR_TX_HOLD, 32'hff, 32'h5c, "tx holding readback");
    wait_st(ST_TX_END, 1'b1, "tx end nack");
    wait_st(ST_BUSY, 1'b0, "idle nack");
    rdc(ADDR_STATUS, 32'h18, 32'h18, "nack seen");
    chk(irq, 1'b1, "nack irq");
    wr(ADDR_STATUS, 32'ha, RESP_OKAY);
    rdc(ADDR_STATUS, 32'ha, 32'h0, "nack cleared");
    chk(irq, 1'b0, "nack irq cleared");
    $display("test nack done");
  endtask

  task automatic t_rx();
    int i;
    @(posedge clk);
    s_nack <= 1'b0;
    s_tx <= 1'b1;
    s_str <= 1'b1;
    s_send <= 8'h5a;
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_IRQ_EN, 32'h4, RESP_OKAY);
    rd(ADDR_RX_HOLD, RESP_OKAY);
    wait_st(ST_RX_FULL, 1'b1, "rx full");
    chk(ack_seen, 1'b0, "ack sent");
    s_send <= 8'hc3;
    wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    chk(irq, 1'b1, "rx full irq");
    rdc(ADDR_RX_HOLD, 32'hff, 32'h5a, "first byte");
    rdc(ADDR_STATUS, 32'h4, 32'h0, "rx full cleared");
    wait_st(ST_RX_FULL, 1'b1, "second byte");
    chk(ack_seen, 1'b1, "nack sent");
    nb = s_nb;
    wr(ADDR_CTRL, 32'h6, RESP_OKAY);
    rdc(ADDR_CTRL, 32'h7, 32'h6, "ctrl readback");
    rdc(ADDR_RX_HOLD, 32'hff, 32'hc3, "final byte");
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (scl !== 1'b0) chk(scl, 1'b0, "clock after final");
    end
    rdc(ADDR_STATUS, 32'h24, 32'h0, "no further byte");
    chk(s_nb, nb, "no further clocks");
    $display("test receive done");
  endtask

  initial begin
    #3000000;
    hang("run");
  end

  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst = 1'b1;
    aw_a = 8'h00;
    ar_a = 8'h00;
    w_d = 32'h0;
    w_s = 4'hf;
    aw_v = 1'b0;
    w_v = 1'b0;
    b_y = 1'b0;
    ar_v = 1'b0;
    r_y = 1'b0;
    s_tx = 1'b0;
    s_nack = 1'b0;
    s_str = 1'b0;
    s_send = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_nack();
    t_rx();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== logic/ibt_master_top.sv ====
// I2C master byte path: registers, flags, interrupts and AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ibt_master_top #(
  parameter int unsigned HALF_CYC = ibt_pkg::SCL_HALF_CYC
) (
  // Clock and reset
  input  wire logic                       SYS_CLK_I,
  input  wire logic                       RST_I,
  // AXI4-Lite write address
  input  wire logic [ibt_pkg::AXI_AW-1:0] S_AXI_AWADDR_I,
  input  wire logic                       S_AXI_AWVALID_I,
  output logic                            S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input  wire logic [31:0]                S_AXI_WDATA_I,
  input  wire logic [3:0]                 S_AXI_WSTRB_I,
  input  wire logic                       S_AXI_WVALID_I,
  output logic                            S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0]                      S_AXI_BRESP_O,
  output logic                            S_AXI_BVALID_O,
  input  wire logic                       S_AXI_BREADY_I,
  // AXI4-Lite read address
  input  wire logic [ibt_pkg::AXI_AW-1:0] S_AXI_ARADDR_I,
  input  wire logic                       S_AXI_ARVALID_I,
  output logic                            S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0]                     S_AXI_RDATA_O,
  output logic [1:0]                      S_AXI_RRESP_O,
  output logic                            S_AXI_RVALID_O,
  input  wire logic                       S_AXI_RREADY_I,
  // I2C clock line, open drain
  input  wire logic                       SCL_I,
  output logic                            SCL_O,
  output logic                            SCL_OE_O,
  // I2C data line, open drain
  input  wire logic                       SDA_I,
  output logic                            SDA_O,
  output logic                            SDA_OE_O,
  // Interrupt
  output logic                            IRQ_O
);
  import ibt_pkg::*;

  typedef struct packed {
    logic [1:0]        scl_sy;
    logic [1:0]        sda_sy;
    logic              aw_f;
    logic [AXI_AW-1:0] aw_a;
    logic              w_f;
    logic [31:0]       w_d;
    logic [3:0]        w_s;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [2:0]        ctrl;
    ibt_flags_type     flags;
    logic [3:0]        irq_en;
    logic [7:0]        tx_hold;
    logic              tx_full;
    logic [7:0]        rx_hold;
    logic              rx_go;
    logic              ack_rx;
    logic              irq;
  } ibt_top_state_type;

  ibt_top_state_type st_q;
  ibt_top_state_type st_d;

  logic        aw_rdy;
  logic        w_rdy;
  logic        ar_rdy;
  logic        wr_go;
  logic        wr_lo;
  logic        wr_tx;
  logic        rd_go;
  logic        rd_rx;
  logic        rd_launch;
  logic        tx_mode;
  logic        hold_off;
  logic        eng_start;
  logic        eng_idle;
  logic        scl_oe;
  logic        sda_oe;
  ibt_evt_type eng_evt;

  ibt_bit_engine #(
    .HALF_CYC (HALF_CYC)
  ) u_engine (
    .clk_i      (SYS_CLK_I),
    .rst_i      (RST_I),
    .start_i    (eng_start),
    .tx_mode_i  (tx_mode),
    .tx_byte_i  (st_q.tx_hold),
    .ack_send_i (st_q.ctrl[CTRL_ACK]),
    .idle_o     (eng_idle),
    .evt_o      (eng_evt),
    .scl_i      (st_q.scl_sy[1]),
    .sda_i      (st_q.sda_sy[1]),
    .scl_oe_o   (scl_oe),
    .sda_oe_o   (sda_oe)
  );

  // One write and one read in flight; a held response blocks the next
  assign aw_rdy = !st_q.aw_f && !st_q.bvalid;
  assign w_rdy  = !st_q.w_f && !st_q.bvalid;
  assign ar_rdy = !st_q.rvalid;
  assign wr_go  = st_q.aw_f && st_q.w_f && !st_q.bvalid;
  assign wr_lo  = wr_go && st_q.w_s[0];
  assign wr_tx  = wr_lo && (st_q.aw_a == ADDR_TX_HOLD);
  assign rd_go  = S_AXI_ARVALID_I && ar_rdy;
  assign rd_rx  = rd_go && (S_AXI_ARADDR_I == ADDR_RX_HOLD);

  assign tx_mode  = st_q.ctrl[CTRL_TX_MODE];
  assign hold_off = st_q.ctrl[CTRL_HOLD];
  // Hold-off set: the read just drains the last byte, no new clocks
  assign rd_launch = rd_rx && !hold_off && !tx_mode; // RL1 RL4 RL5
  // Holding byte moves to the shifter as soon as the engine is free
  assign eng_start = eng_idle &&
                     (tx_mode ? st_q.tx_full : st_q.rx_go); // RL9 RL1

  always_comb begin
    st_d = st_q;
    // Pins come from another domain: two flops before any use
    st_d.scl_sy = {st_q.scl_sy[0], SCL_I};
    st_d.sda_sy = {st_q.sda_sy[0], SDA_I};

    if (S_AXI_AWVALID_I && aw_rdy) begin
      st_d.aw_f = 1'b1;
      st_d.aw_a = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && w_rdy) begin
      st_d.w_f = 1'b1;
      st_d.w_d = S_AXI_WDATA_I;
      st_d.w_s = S_AXI_WSTRB_I;
    end
    if (st_q.bvalid && S_AXI_BREADY_I) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && S_AXI_RREADY_I) begin
      st_d.rvalid = 1'b0;
    end

    // Register writes; all fields sit in byte lane 0
    if (wr_go) begin
      st_d.aw_f = 1'b0;
      st_d.w_f = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OKAY;
      case (st_q.aw_a)
        ADDR_CTRL: if (wr_lo) begin
          st_d.ctrl = st_q.w_d[2:0];
        end
        ADDR_STATUS: if (wr_lo) begin
          st_d.flags = ibt_flags_type'(st_q.flags & ~st_q.w_d[3:0]);
        end
        ADDR_IRQ_EN: if (wr_lo) begin
          st_d.irq_en = st_q.w_d[3:0];
        end
        ADDR_TX_HOLD: if (wr_lo) begin
          // Accepted even mid-byte, so bytes follow back to back
          st_d.tx_hold = st_q.w_d[7:0]; // RL10
          st_d.tx_full = 1'b1;
          st_d.flags.tx_empty = 1'b0; // RL19
        end
        ADDR_RX_HOLD: begin
        end
        default: st_d.bresp = RESP_SLVERR;
      endcase
    end

    // Register reads
    if (rd_go) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = RESP_OKAY;
      st_d.rdata = 32'h0;
      case (S_AXI_ARADDR_I)
        ADDR_CTRL: st_d.rdata[2:0] = st_q.ctrl;
        ADDR_STATUS: begin
          st_d.rdata[3:0] = st_q.flags;
          st_d.rdata[ST_ACK_RX] = st_q.ack_rx;
          st_d.rdata[ST_BUSY] = !eng_idle;
        end
        ADDR_IRQ_EN: st_d.rdata[3:0] = st_q.irq_en;
        ADDR_TX_HOLD: st_d.rdata[7:0] = st_q.tx_hold;
        ADDR_RX_HOLD: begin
          st_d.rdata[7:0] = st_q.rx_hold;
          st_d.flags.rx_full = 1'b0; // RL19
        end
        default: st_d.rresp = RESP_SLVERR;
      endcase
    end

    // A launch request waits here until the engine is free
    if (rd_launch) begin
      st_d.rx_go = 1'b1;
    end else if (eng_start && !tx_mode) begin
      st_d.rx_go = 1'b0;
    end else if (tx_mode) begin
      st_d.rx_go = 1'b0;
    end

    // Hardware events come last so a set wins over a clear, except that a tx holding write in the same cycle keeps tx_empty clear
    if (eng_start && tx_mode) begin
      st_d.tx_full = wr_tx;
      st_d.flags.tx_empty = !wr_tx; // RL11
    end
    if (eng_evt.ninth && tx_mode && st_q.flags.tx_empty) begin
      st_d.flags.tx_end = 1'b1; // RL13
    end
    if (eng_evt.done) begin
      if (tx_mode) begin
        st_d.ack_rx = eng_evt.ack; // RL15
        if (eng_evt.ack) begin
          st_d.flags.nack = 1'b1; // RL16
        end
      end else begin
        st_d.rx_hold = eng_evt.data;
        st_d.flags.rx_full = 1'b1; // RL2 RL8
      end
    end

    // One level line for all four sources
    st_d.irq = |(st_q.flags & st_q.irq_en); // RL3 RL12 RL14 RL16
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= '0;
      st_q.scl_sy <= 2'h3;
      st_q.sda_sy <= 2'h3;
      st_q.ctrl <= CTRL_RST;
      st_q.flags <= ibt_flags_type'(FLAGS_RST);
      st_q.irq_en <= IRQ_EN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign S_AXI_AWREADY_O = aw_rdy;
  assign S_AXI_WREADY_O  = w_rdy;
  assign S_AXI_BRESP_O   = st_q.bresp;
  assign S_AXI_BVALID_O  = st_q.bvalid;
  assign S_AXI_ARREADY_O = ar_rdy;
  assign S_AXI_RDATA_O   = st_q.rdata;
  assign S_AXI_RRESP_O   = st_q.rresp;
  assign S_AXI_RVALID_O  = st_q.rvalid;
  // Open drain: only ever pull low, release otherwise
  assign SCL_O    = 1'b0;
  assign SDA_O    = 1'b0;
  assign SCL_OE_O = scl_oe;
  assign SDA_OE_O = sda_oe;
  assign IRQ_O    = st_q.irq;

  property p_rx_launch;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (rd_rx && !hold_off && !tx_mode && eng_idle) |-> ##2 !eng_idle;
  endproperty
  a_rx_launch: assert property (p_rx_launch) // RL1
    else $error("rx holding read did not launch a byte");

  property p_hold_off;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (rd_rx && hold_off && !tx_mode && eng_idle && !st_q.rx_go)
      |-> ##1 (!tx_mode && eng_idle) ##1 eng_idle;
  endproperty
  a_hold_off: assert property (p_hold_off) // RL4
    else $error("byte clocked despite hold-off");

  property p_rx_full;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (eng_evt.done && !tx_mode)
      |=> st_q.flags.rx_full && (st_q.rx_hold == $past(eng_evt.data));
  endproperty
  a_rx_full: assert property (p_rx_full) // RL2
    else $error("received byte not flagged");

  property p_rx_irq;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q.flags.rx_full && st_q.irq_en[ST_RX_FULL]) |=> IRQ_O;
  endproperty
  a_rx_irq: assert property (p_rx_irq) // RL3
    else $error("receive-full interrupt missing");

  property p_tx_move;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (tx_mode && st_q.tx_full && eng_idle && !wr_tx)
      |=> st_q.flags.tx_empty && !st_q.tx_full && !eng_idle;
  endproperty
  a_tx_move: assert property (p_tx_move) // RL11
    else $error("holding byte not moved or tx-empty not set");

  property p_tx_accept;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    wr_tx |=> st_q.tx_full && !st_q.flags.tx_empty
      && (st_q.tx_hold == $past(st_q.w_d[7:0]));
  endproperty
  a_tx_accept: assert property (p_tx_accept) // RL10
    else $error("tx holding write not accepted");

  property p_tx_irq;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q.flags.tx_empty && st_q.irq_en[ST_TX_EMPTY]) |=> IRQ_O;
  endproperty
  a_tx_irq: assert property (p_tx_irq) // RL12
    else $error("tx-empty interrupt missing");

  property p_tx_end;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (eng_evt.ninth && tx_mode && st_q.flags.tx_empty)
      |=> st_q.flags.tx_end;
  endproperty
  a_tx_end: assert property (p_tx_end) // RL13
    else $error("tx-end not set at ninth clock");

  property p_end_irq;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q.flags.tx_end && st_q.irq_en[ST_TX_END]) |=> IRQ_O;
  endproperty
  a_end_irq: assert property (p_end_irq) // RL14
    else $error("tx-end interrupt missing");

  property p_ack_rx;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (eng_evt.done && tx_mode)
      |=> (st_q.ack_rx == $past(eng_evt.ack))
          && (!st_q.ack_rx || st_q.flags.nack);
  endproperty
  a_ack_rx: assert property (p_ack_rx) // RL15
    else $error("returned ack not captured");

  property p_nack_irq;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q.flags.nack && st_q.irq_en[ST_NACK]) |=> IRQ_O;
  endproperty
  a_nack_irq: assert property (p_nack_irq) // RL16
    else $error("nack interrupt missing");

  property p_rx_clear;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (rd_rx && !(eng_evt.done && !tx_mode)) |=> !st_q.flags.rx_full;
  endproperty
  a_rx_clear: assert property (p_rx_clear) // RL19
    else $error("rx-full not cleared by read");
endmodule
`default_nettype wire

// ==== logic/ibt_pkg.sv ====
// Package and serial bit engine of the I2C master byte path
// Notes on behaviour
// [RL1] Reading rx holding register launches next received byte unless hold-off.
// [RL2] Receive-full flag sets when a received byte lands in holding register.
// [RL3] Receive-full flag with its enable raises the interrupt.
// [RL4] Hold-off set: read launches no byte; clear: read launches one.
// [RL5] Hold-off one stops clocks after final byte; zero allows streaming.
// [RL6] Host sets hold-off and ack value before reading rx holding.
// [RL7] Receive mode drives ack value on ninth bit; 0 ack, 1 nack.
// [RL8] Ack bit already driven when receive-full flag reads one.
// [RL9] Tx holding write starts sending once byte moves to shifter.
// [RL10] Next tx byte accepted while current one still shifts.
// [RL11] Tx-empty flag sets when holding moves into the shifter.
// [RL12] Tx-empty flag with its enable raises the interrupt.
// [RL13] Tx-end flag sets at ninth SCL rise if tx-empty is one.
// [RL14] Tx-end flag with its enable raises the interrupt.
// [RL15] Transmit mode stores returned ack bit; 0 ack, 1 nack.
// [RL16] Not-acknowledge received raises its own maskable interrupt.
// [RL17] Slave takes memory address as two bytes after slave address.
// [RL18] Host puts slave address in bits 7:1, direction in bit 0.
// [RL19] Rx holding read clears rx-full; tx holding write clears tx-empty.
`timescale 1ns/1ps
`default_nettype none
package ibt_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SCL_PERIOD_NS = 400;
  localparam int unsigned SCL_HALF_CYC =
    (SCL_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h08;
  localparam logic [7:0] ADDR_TX_HOLD = 8'h0c;
  localparam logic [7:0] ADDR_RX_HOLD = 8'h10;
  localparam int CTRL_TX_MODE = 0;
  localparam int CTRL_HOLD    = 1;
  localparam int CTRL_ACK     = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_TX_END   = 1;
  localparam int ST_RX_FULL  = 2;
  localparam int ST_NACK     = 3;
  localparam int ST_ACK_RX   = 4;
  localparam int ST_BUSY     = 5;
  localparam logic [3:0] FLAGS_RST  = 4'h1;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic nack;
    logic rx_full;
    logic tx_end;
    logic tx_empty;
  } ibt_flags_type;
  typedef struct packed {
    logic       done;
    logic       ninth;
    logic       ack;
    logic [7:0] data;
  } ibt_evt_type;
  typedef enum logic [1:0] {E_IDLE, E_LOW, E_RISE, E_HIGH} ibt_eng_type;
endpackage

module ibt_bit_engine #(
  parameter int unsigned HALF_CYC = ibt_pkg::SCL_HALF_CYC
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Byte request
  input  wire logic              start_i,
  input  wire logic              tx_mode_i,
  input  wire logic [7:0]        tx_byte_i,
  input  wire logic              ack_send_i,
  output logic                   idle_o,
  output ibt_pkg::ibt_evt_type   evt_o,
  // Synchronised bus levels and drives
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   scl_oe_o,
  output logic                   sda_oe_o
);
  import ibt_pkg::*;
  localparam logic [7:0] HC = 8'(HALF_CYC - 1);
  typedef struct packed {
    ibt_eng_type st;
    logic [7:0]  cnt;
    logic [3:0]  bit_n;
    logic [7:0]  sh;
    logic        smp;
    logic        tx;
    logic        ack_s;
    logic        held;
    ibt_evt_type evt;
  } ibt_eng_state_type;
  ibt_eng_state_type st_q;
  ibt_eng_state_type st_d;
  logic              last_bit;
  logic              drv;

  assign last_bit = (st_q.bit_n == 4'h8);
  // Ninth bit: receive drives ack value, transmit releases for slave
  assign drv = last_bit ? (!st_q.tx && !st_q.ack_s) // RL7
                        : (st_q.tx && !st_q.sh[7]);
  assign idle_o   = (st_q.st == E_IDLE);
  // SCL stays low between bytes so the slave waits for us
  assign scl_oe_o = (st_q.st == E_LOW) || (idle_o && st_q.held);
  assign sda_oe_o = !idle_o && drv;
  assign evt_o    = st_q.evt;

  always_comb begin
    st_d = st_q;
    st_d.evt.done = 1'b0;
    st_d.evt.ninth = 1'b0;
    case (st_q.st)
      E_IDLE: if (start_i) begin
        st_d.st = E_LOW;
        st_d.cnt = HC;
        st_d.bit_n = 4'h0;
        st_d.sh = tx_byte_i;
        st_d.tx = tx_mode_i;
        st_d.ack_s = ack_send_i;
      end
      E_LOW: if (st_q.cnt == 8'h00) st_d.st = E_RISE;
             else st_d.cnt = st_q.cnt - 8'h01;
      // Waits for the line itself, so a stretching slave is honoured
      E_RISE: if (scl_i) begin
        st_d.st = E_HIGH;
        st_d.cnt = HC;
        st_d.smp = sda_i;
        if (last_bit) begin
          st_d.evt.ninth = 1'b1;
          st_d.evt.ack = sda_i;
        end
      end
      E_HIGH: if (st_q.cnt != 8'h00) begin
        st_d.cnt = st_q.cnt - 8'h01;
      end else if (last_bit) begin
        st_d.st = E_IDLE;
        st_d.held = 1'b1;
        st_d.evt.done = 1'b1;
        st_d.evt.data = st_q.sh;
      end else begin
        // Shift in the same cycle that pulls SCL low, so SDA never moves while high
        st_d.sh = {st_q.sh[6:0], st_q.smp};
        st_d.bit_n = st_q.bit_n + 4'h1;
        st_d.cnt = HC;
        st_d.st = E_LOW;
      end
      default: st_d.st = E_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  property p_ack_drive;
    @(posedge clk_i) disable iff (rst_i)
    (st_q.st == E_HIGH && last_bit && !st_q.tx)
      |-> (sda_oe_o == !st_q.ack_s);
  endproperty
  a_ack_drive: assert property (p_ack_drive) // RL7
    else $error("ack value not driven on ninth bit");

  property p_ack_before_done;
    @(posedge clk_i) disable iff (rst_i)
    (st_q.evt.done && !st_q.tx)
      |-> ($past(sda_oe_o) == !st_q.ack_s) && !$past(scl_oe_o);
  endproperty
  a_ack_before_done: assert property (p_ack_before_done) // RL8
    else $error("receive byte ended without ack driven");
endmodule
`default_nettype wire
